// >>> ebac_master.sv
`timescale 1ns/1ps
`default_nettype none
// Internal bus master: raises a request and holds it until its access ends
module ebac_master (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire ebac_pkg::ebac_req_type i_cmd,
  input wire logic i_done,
  output var ebac_pkg::ebac_req_type o_req
);
  // On release the payload is inverted so stale values never look valid
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_req <= '0;
    end else if (i_start) begin
      o_req <= i_cmd;
    end else if (i_done && o_req.req) begin
      o_req <= ~o_req;
    end
  end
endmodule : ebac_master
`default_nettype wire

// >>> ebac_pkg.sv
package ebac_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] REG_WIDTH_SEL = 4'h0;  // area_width_select, one bit per area
  localparam logic [3:0] REG_STATE_SEL = 4'h4;  // area_state_select, one bit per area
  localparam logic [3:0] REG_WAIT_A = 4'h8;     // wait_count_select_a, areas 7..4
  localparam logic [3:0] REG_WAIT_B = 4'hc;     // wait_count_select_b, areas 3..0

  // Area and master counts
  localparam int N_AREA = 8;
  localparam int N_MAST = 4;
  localparam int WAIT_W = 3;   // 0 to 7 program waits
  localparam int WAIT_FLD = 4; // each wait field sits in a nibble

  // Reset values
  localparam logic [7:0] WIDTH_RST = 8'hff;     // all areas 16-bit
  localparam logic [7:0] STATE_RST = 8'hff;     // all areas 3-state
  localparam logic [15:0] WAIT_RST = 16'h7777;  // maximum waits

  // Fixed internal access shape
  localparam logic [3:0] INT_STATES = 4'h1;     // single state for on-chip space
  localparam logic [3:0] TWO_STATES = 4'h2;
  localparam logic [3:0] THREE_STATES = 4'h3;

  // Master indices, highest priority first
  localparam int M_EXDMA = 3;
  localparam int M_DMA = 2;
  localparam int M_XFER = 1;
  localparam int M_CPU = 0;

  // Area kinds
  typedef enum logic [1:0] {
    EBAC_SPACE_INT = 2'h0,   // on-chip memory or internal register
    EBAC_SPACE_EXT = 2'h1,   // plain external area
    EBAC_SPACE_DRAM = 2'h2,  // DRAM, synchronous DRAM or burst ROM
    EBAC_SPACE_RSV = 2'h3
  } ebac_space_type;

  // One master's bus request
  typedef struct packed {
    logic req;
    ebac_space_type space;
    logic [2:0] area;
    logic wr;
    logic hi_byte;   // byte access targets the odd byte
    logic word;
    logic [15:0] wdata;
  } ebac_req_type;

  // External bus cycle as driven to the pins
  typedef struct packed {
    logic active;
    logic [2:0] area;
    logic rd_n;
    logic hwr_n;
    logic lwr_n;
    logic [15:0] dout;
    logic [15:0] doe;
  } ebac_ext_type;

  // Bus cycle sequencer states, gray coded
  typedef enum logic [1:0] {
    EBAC_IDLE = 2'b00,
    EBAC_T1 = 2'b01,
    EBAC_T2 = 2'b11,
    EBAC_T3 = 2'b10
  } ebac_state_type;

endpackage : ebac_pkg

// >>> ebac_prio.sv
`timescale 1ns/1ps
`default_nettype none

// Fixed priority pick among four master requests
module ebac_prio (
  input wire logic [3:0] i_req,
  output logic [3:0] o_onehot
);

  // Highest index wins; lower ones see the mask of those above
  genvar g;
  generate
    for (g = 0; g < ebac_pkg::N_MAST; g++) begin : g_pick
      if (g == ebac_pkg::N_MAST - 1) begin : g_top
        assign o_onehot[g] = i_req[g];
      end else begin : g_low
        assign o_onehot[g] = i_req[g] & ~(|i_req[ebac_pkg::N_MAST-1:g+1]);
      end
    end
  endgenerate

endmodule : ebac_prio

`default_nettype wire

// >>> ebac_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for area timing and grants
module ebac_properties (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_av_address,
  input wire logic i_av_write,
  input wire logic [31:0] i_av_writedata,
  input wire logic o_av_waitrequest,
  input wire ebac_pkg::ebac_req_type i_mreq [4],
  input wire logic [3:0] o_ack,
  input wire logic [3:0] o_done,
  input wire logic i_refresh_req,
  input wire logic i_release_req,
  input wire ebac_pkg::ebac_ext_type o_ext,
  input wire logic o_release_ack,
  input wire logic o_bus16_mode
);
  logic [7:0] width_sh; // Shadow of the width setting
  logic [7:0] state_sh; // Shadow of the state setting
  logic [1:0] settle; // Cycles since a setting write, saturating
  logic [3:0] reqv; // All request lines
  logic dram_on; // Granted master targets DRAM-type space
  assign reqv = {i_mreq[3].req, i_mreq[2].req, i_mreq[1].req, i_mreq[0].req};
  // DRAM targets use their own state count, so they leave the three-state check
  always_comb begin
    dram_on = 1'b0;
    for (int m = 0; m < 4; m++) begin
      dram_on |= o_ack[m] && (i_mreq[m].space == ebac_pkg::EBAC_SPACE_DRAM);
    end
  end
  // Track settings; registered outputs lag a write, hence the settle count
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      width_sh <= ebac_pkg::WIDTH_RST;
      state_sh <= ebac_pkg::STATE_RST;
      settle <= 2'h0;
    end else if (i_av_write && !o_av_waitrequest) begin
      if (i_av_address == ebac_pkg::REG_WIDTH_SEL) width_sh <= i_av_writedata[7:0];
      if (i_av_address == ebac_pkg::REG_STATE_SEL) state_sh <= i_av_writedata[7:0];
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_grant_onehot: assert property ($onehot0(o_ack))
    else $error("two grants at once");
  a_fixed_prio: assert property ($past(o_ack) == 4'h0 && o_ack != 4'h0 &&
    !$past(i_refresh_req) && !$past(i_release_req) |->
    ($past(reqv) & ~$past(o_done) & ~((o_ack << 1) - 4'h1)) == 4'h0)
    else $error("lower master won");
  a_bus16_mode: assert property (settle == 2'h3 |-> o_bus16_mode == (|width_sh))
    else $error("bus mode wrong");
  a_low_strobe: assert property (settle == 2'h3 && o_ext.active &&
    !width_sh[o_ext.area] |-> o_ext.lwr_n) else $error("low strobe driven");
  a_upper_lanes: assert property (settle == 2'h3 && o_ext.active &&
    !width_sh[o_ext.area] |-> o_ext.doe[7:0] == 8'h00) else $error("low lanes driven");
  a_two_state: assert property ($rose(o_ext.active) && !state_sh[o_ext.area]
    |-> ##2 (|o_done)) else $error("two-state cycle length");
  a_three_state: assert property ($rose(o_ext.active) && state_sh[o_ext.area] &&
    !dram_on |-> (o_done == 4'h0) [*3]) else $error("three-state cycle too short");
  a_grant_hold: assert property (o_ext.active && o_done == 4'h0 |=>
    o_ack == $past(o_ack) || o_done != 4'h0) else $error("grant moved mid cycle");
  a_release_first: assert property (!o_ext.active && i_release_req &&
    !i_mreq[ebac_pkg::M_EXDMA].req |=> !o_ext.active) else $error("access during release");
  c_release: cover property ($rose(o_release_ack));
  c_three: cover property ($rose(o_ext.active) && state_sh[o_ext.area]);
  c_contend: cover property (o_ack[3] && reqv[0]);
endmodule : ebac_properties
bind ebac_top ebac_properties i_ebac_properties (.i_mclk, .i_rst_n, .i_av_address,
  .i_av_write, .i_av_writedata, .o_av_waitrequest, .i_mreq, .o_ack, .o_done,
  .i_refresh_req, .i_release_req, .o_ext, .o_release_ack, .o_bus16_mode);
`default_nettype wire

// >>> ebac_top.sv
`timescale 1ns/1ps
`default_nettype none

module ebac_top (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Avalon-MM slave
  input wire logic [3:0] i_av_address,
  input wire logic i_av_read,
  input wire logic i_av_write,
  input wire logic [31:0] i_av_writedata,
  input wire logic [3:0] i_av_byteenable,
  output logic [31:0] o_av_readdata,
  output logic o_av_waitrequest,
  // Masters
  input wire ebac_pkg::ebac_req_type i_mreq [4],
  output logic [3:0] o_ack,
  output logic [3:0] o_done,
  output logic [15:0] o_rdata,
  // External side
  input wire logic i_wait_n,
  input wire logic [15:0] i_ext_din,
  input wire logic i_refresh_req,
  input wire logic i_refresh_parallel_mode,
  input wire logic i_release_req,
  output var ebac_pkg::ebac_ext_type o_ext,
  output logic o_refresh_ack,
  output logic o_release_ack,
  output logic o_bus16_mode
);

  // Configuration registers
  logic [7:0] width_reg;
  logic [7:0] state_reg;
  logic [31:0] wait_reg; // One nibble per area: B in 15..0, A in 31..16
  logic rd_pend_reg; // read answer stage, one wait cycle per read

  // Arbitration and sequencer state
  ebac_pkg::ebac_state_type st_reg, st_next;
  logic [3:0] ack_reg;            // grant on the internal bus
  logic [3:0] ext_own_reg;        // master owning the external cycle
  logic [2:0] wcnt_reg;           // program wait count left
  logic [3:0] done_reg;
  logic [15:0] rdata_reg;
  ebac_pkg::ebac_ext_type ext_reg;
  logic refresh_ack_reg;
  logic release_ack_reg;
  logic bus16_reg;
  logic cur3_reg;   // Current cycle is three-state
  logic cur16_reg;  // Current cycle uses the full 16-bit bus
  logic curwr_reg;  // Current cycle is a write

  // Avalon decode
  wire bus_wr = i_av_write & i_ce;
  wire sel_width = (i_av_address == ebac_pkg::REG_WIDTH_SEL);
  wire sel_state = (i_av_address == ebac_pkg::REG_STATE_SEL);
  wire sel_wa = (i_av_address == ebac_pkg::REG_WAIT_A);
  wire sel_wb = (i_av_address == ebac_pkg::REG_WAIT_B);
  wire [31:0] rd_mux =
    sel_width ? {24'h000000, width_reg} :
    sel_state ? {24'h000000, state_reg} :
    sel_wa ? {16'h0000, wait_reg[31:16]} :
    sel_wb ? {16'h0000, wait_reg[15:0]} :
    32'h00000000; // Unmapped reads return zero

  // Register writes complete at once; reads cost one extra cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      width_reg <= ebac_pkg::WIDTH_RST;
      state_reg <= ebac_pkg::STATE_RST;
      wait_reg <= {ebac_pkg::WAIT_RST, ebac_pkg::WAIT_RST};
      rd_pend_reg <= 1'b0;
      o_av_readdata <= 32'h00000000;
    end else if (i_ce) begin
      if (bus_wr && i_av_byteenable[0]) begin
        if (sel_width) width_reg <= i_av_writedata[7:0];
        if (sel_state) state_reg <= i_av_writedata[7:0];
      end
      // Wait fields: A holds areas 7..4, B holds areas 3..0
      // Four areas per register need two byte lanes
      if (bus_wr && sel_wa) begin
        if (i_av_byteenable[0]) wait_reg[23:16] <= i_av_writedata[7:0] & 8'h77;
        if (i_av_byteenable[1]) wait_reg[31:24] <= i_av_writedata[15:8] & 8'h77;
      end
      if (bus_wr && sel_wb) begin
        if (i_av_byteenable[0]) wait_reg[7:0] <= i_av_writedata[7:0] & 8'h77;
        if (i_av_byteenable[1]) wait_reg[15:8] <= i_av_writedata[15:8] & 8'h77;
      end
      rd_pend_reg <= i_av_read & ~rd_pend_reg;
      o_av_readdata <= rd_mux;
    end
  end

  // Waitrequest falls in the second cycle of a read so data are settled
  assign o_av_waitrequest = i_av_read & ~rd_pend_reg;

  // Wait field of an area; area 0 sits in the low nibble of B
  function automatic logic [2:0] wait_of(input logic [31:0] w, input logic [2:0] a);
    logic [3:0] nib;
    nib = 4'h0;
    case (a)
      3'h0: nib = w[3:0];
      3'h1: nib = w[7:4];
      3'h2: nib = w[11:8];
      3'h3: nib = w[15:12];
      3'h4: nib = w[19:16];
      3'h5: nib = w[23:20];
      3'h6: nib = w[27:24];
      default: nib = w[31:28];
    endcase
    return nib[2:0];
  endfunction : wait_of

  // Requests split by where they go
  logic [3:0] req_any, req_ext, req_int;
  genvar g;
  generate
    for (g = 0; g < ebac_pkg::N_MAST; g++) begin : g_split
      // A master sees its done pulse one edge late, so its request is ignored then
      assign req_any[g] = i_mreq[g].req & ~done_reg[g];
      assign req_ext[g] = req_any[g] & (i_mreq[g].space != ebac_pkg::EBAC_SPACE_INT);
      assign req_int[g] = req_any[g] & (i_mreq[g].space == ebac_pkg::EBAC_SPACE_INT);
    end
  endgenerate

  // Internal bus winner among all requests
  logic [3:0] pick;
  ebac_prio u_prio (
    .i_req(req_any),
    .o_onehot(pick)
  );

  // Who is the picked master and where it goes
  wire pick_exdma = pick[ebac_pkg::M_EXDMA];
  wire pick_ext = |(pick & req_ext);
  logic [1:0] pick_idx;
  always_comb begin
    pick_idx = 2'h0;
    for (int k = 0; k < ebac_pkg::N_MAST; k++) begin
      if (pick[k]) pick_idx = k[1:0];
    end
  end
  ebac_pkg::ebac_req_type preq;
  assign preq = i_mreq[pick_idx];
  wire pick_dram = preq.space == ebac_pkg::EBAC_SPACE_DRAM;

  // External bus may be claimed by refresh, release or a master
  // Refresh with parallel mode 0 coexists with non-DRAM external access
  wire refresh_blocks = i_refresh_req & (i_refresh_parallel_mode | pick_dram);
  // Release outranks every external master except external DMA
  wire release_blocks = i_release_req & ~pick_exdma;
  // External DMA only waits for a refresh, never for release
  wire ext_go = pick_ext & ~refresh_blocks & ~release_blocks;
  wire boundary = (st_reg == ebac_pkg::EBAC_IDLE);

  // Access shape of the picked area
  wire area16 = width_reg[preq.area];
  wire area3 = state_reg[preq.area];
  // DRAM-type areas run their own fixed two-state timing
  wire use3 = area3 & ~pick_dram;
  wire [2:0] pwait = use3 ? wait_of(wait_reg, preq.area) : 3'h0;

  // Cycle sequencer: T1, T2, optional T3 with waits
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ebac_pkg::EBAC_IDLE: begin
        if (ext_go) st_next = ebac_pkg::EBAC_T1;
      end
      ebac_pkg::EBAC_T1: begin
        st_next = ebac_pkg::EBAC_T2;
      end
      ebac_pkg::EBAC_T2: begin
        // Two-state areas end here, no wait ever looked at
        if (ext_reg.active && cur3_reg) st_next = ebac_pkg::EBAC_T3;
        else st_next = ebac_pkg::EBAC_IDLE;
      end
      ebac_pkg::EBAC_T3: begin
        // Hold while program waits remain or the wait pin is low
        if (wcnt_reg == 3'h0 && i_wait_n) st_next = ebac_pkg::EBAC_IDLE;
      end
      default: st_next = ebac_pkg::EBAC_IDLE;
    endcase
  end

  // Lane mapping: 8-bit areas live on D15..D8
  wire [15:0] wdata_lanes = area16 ? preq.wdata : {preq.wdata[7:0], 8'h00};
  wire [15:0] oe_lanes = area16 ? 16'hffff : 16'hff00;
  wire lwr_use = area16 & (preq.word | ~preq.hi_byte);
  wire hwr_use = ~area16 | preq.word | preq.hi_byte;
  wire [15:0] rd_lanes = cur16_reg ? i_ext_din : {8'h00, i_ext_din[15:8]};

  // Sequencer, grant and pin registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= ebac_pkg::EBAC_IDLE;
      ack_reg <= 4'h0;
      ext_own_reg <= 4'h0;
      wcnt_reg <= 3'h0;
      done_reg <= 4'h0;
      rdata_reg <= 16'h0000;
      ext_reg <= '{active: 1'b0, area: 3'h0, rd_n: 1'b1, hwr_n: 1'b1, lwr_n: 1'b1,
                   dout: 16'h0000, doe: 16'h0000};
      cur3_reg <= 1'b0;
      cur16_reg <= 1'b0;
      curwr_reg <= 1'b0;
      refresh_ack_reg <= 1'b0;
      release_ack_reg <= 1'b0;
      bus16_reg <= 1'b0;
    end else if (i_ce) begin
      st_reg <= st_next;
      bus16_reg <= |width_reg;
      done_reg <= 4'h0;
      if (boundary) begin
        // Grants move only between cycles
        ack_reg <= pick & (req_int | {4{ext_go}});
        refresh_ack_reg <= i_refresh_req;
        // Release ack parallels internal work, but not an external DMA cycle or a blocking refresh
        release_ack_reg <= i_release_req & ~(ext_go & pick_exdma) & ~refresh_blocks;
        // Internal access: one state, fixed shape
        if (|(pick & req_int)) done_reg <= pick & req_int;
        if (|(pick & req_int)) rdata_reg <= 16'h0000;
      end
      if (boundary && ext_go) begin
        ext_own_reg <= pick;
        cur3_reg <= use3;
        cur16_reg <= area16;
        curwr_reg <= preq.wr;
        wcnt_reg <= pwait;
        ext_reg.active <= 1'b1;
        ext_reg.area <= preq.area;
        ext_reg.rd_n <= preq.wr;
        ext_reg.hwr_n <= ~(preq.wr & hwr_use);
        ext_reg.lwr_n <= ~(preq.wr & lwr_use);
        ext_reg.dout <= wdata_lanes;
        ext_reg.doe <= preq.wr ? oe_lanes : 16'h0000;
      end
      if (st_reg == ebac_pkg::EBAC_T3 && wcnt_reg != 3'h0) begin
        wcnt_reg <= wcnt_reg - 3'h1;
      end
      if (st_reg != ebac_pkg::EBAC_IDLE && st_next == ebac_pkg::EBAC_IDLE) begin
        // End of external cycle: return data, drop strobes and grant
        done_reg <= ext_own_reg;
        if (!curwr_reg) rdata_reg <= rd_lanes;
        ext_reg.active <= 1'b0;
        ext_reg.rd_n <= 1'b1;
        ext_reg.hwr_n <= 1'b1;
        ext_reg.lwr_n <= 1'b1;
        ext_reg.doe <= 16'h0000;
        ack_reg <= 4'h0;
      end
    end
  end

  // Outputs straight from flops
  assign o_ack = ack_reg;
  assign o_done = done_reg;
  assign o_rdata = rdata_reg;
  assign o_ext = ext_reg;
  assign o_refresh_ack = refresh_ack_reg;
  assign o_release_ack = release_ack_reg;
  assign o_bus16_mode = bus16_reg;

endmodule : ebac_top

`default_nettype wire

// >>> tb_external_bus_area_control_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: register bus, area timing and arbitration
module tb_external_bus_area_control_arbiter;
  logic clk = 1'b0, rst_n = 1'b0, av_rd = 1'b0, av_wr = 1'b0, av_wait, bus16;
  logic wait_n = 1'b1, rf_req = 1'b0, rf_mode = 1'b0, rl_req = 1'b0, rf_ack, rl_ack;
  logic [3:0] av_addr = 4'h0, ack, done, start = 4'h0;
  logic [31:0] av_wdata = 32'h0, av_rdata, rdat, seed = 32'h1f5f;
  logic [15:0] din = 16'h0, rdata;
  int err_total = 0, compares = 0;
  ebac_pkg::ebac_req_type cmd [4] = '{default: '0};
  ebac_pkg::ebac_req_type mreq [4];
  ebac_pkg::ebac_ext_type ext;
  ebac_top i_ebac_top (.i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_av_address(av_addr),
    .i_av_read(av_rd), .i_av_write(av_wr), .i_av_writedata(av_wdata),
    .i_av_byteenable(4'hf), .o_av_readdata(av_rdata), .o_av_waitrequest(av_wait),
    .i_mreq(mreq), .o_ack(ack), .o_done(done), .o_rdata(rdata), .i_wait_n(wait_n),
    .i_ext_din(din), .i_refresh_req(rf_req), .i_refresh_parallel_mode(rf_mode),
    .i_release_req(rl_req), .o_ext(ext), .o_refresh_ack(rf_ack),
    .o_release_ack(rl_ack), .o_bus16_mode(bus16));
  // One behavioural master per request port
  for (genvar m = 0; m < 4; m++) begin : g_mast
    ebac_master i_ebac_master (.i_mclk(clk), .i_rst_n(rst_n), .i_start(start[m]),
      .i_cmd(cmd[m]), .i_done(done[m]), .o_req(mreq[m]));
  end
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Fixed-seed xorshift
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Avalon master: hold until waitrequest is sampled low, then release
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    av_addr <= a;
    av_wdata <= d;
    av_rd <= rd;
    av_wr <= !rd;
    do @(posedge clk); while (av_wait !== 1'b0);
    rdat = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  // One access by master m; n counts edges from the start edge to done
  task automatic acc(input int m, input ebac_pkg::ebac_space_type sp, input logic [2:0] ar,
                     input logic w, output int n);
    cmd[m] <= '{1'b1, sp, ar, w, 1'b0, 1'b1, 16'(rnd())};
    start[m] <= 1'b1;
    @(posedge clk);
    start[m] <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done[m] !== 1'b1);
  endtask : acc
  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    int n, base, ex;
    logic [31:0] r;
    logic [7:0] wv, sv, pw;
    logic [2:0] ar;
    int q [$];
    ebac_pkg::ebac_space_type sp;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, ebac_pkg::REG_WIDTH_SEL, 32'h0);
    chk("width reset", 32'hff, rdat & 32'hff);
    bus(1'b1, 4'h2, 32'h0);
    chk("unmapped read", 32'h0, rdat);
    bus(1'b1, ebac_pkg::REG_WAIT_A, 32'h0);
    chk("wait A reset", 32'h7777, rdat);
    acc(0, ebac_pkg::EBAC_SPACE_INT, 3'h0, 1'b0, base);
    // Random area settings; the model predicts cycle length and lanes
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      wv = (i == 0) ? 8'h00 : r[7:0];
      sv = r[15:8];
      pw = r[23:16] & 8'h77;
      ar = 3'(i & 1);
      sp = r[24] ? ebac_pkg::EBAC_SPACE_DRAM : ebac_pkg::EBAC_SPACE_EXT;
      bus(1'b0, ebac_pkg::REG_WIDTH_SEL, {24'h0, wv});
      bus(1'b0, ebac_pkg::REG_STATE_SEL, {24'h0, sv});
      bus(1'b0, ebac_pkg::REG_WAIT_B, {24'h0, pw});
      chk("bus16", {31'h0, wv != 8'h00}, {31'h0, bus16});
      din <= r[31:16];
      wait_n <= sv[ar] || !i[1];
      acc(i & 1, sp, ar, r[25], n);
      ex = (r[24] || !sv[ar]) ? 4 : 5 + int'(ar[0] ? pw[6:4] : pw[2:0]);
      chk("cycle length", ex, n);
      if (!r[25]) begin
        chk("read data", wv[ar] ? r[31:16] : r[31:24], wv[ar] ? rdata : rdata[7:0]);
      end
      wait_n <= 1'b1;
    end
    acc(0, ebac_pkg::EBAC_SPACE_INT, 3'h0, 1'b0, n);
    chk("internal length", base, n);
    // Pin wait stretches a three-state cycle with no program waits
    bus(1'b0, ebac_pkg::REG_STATE_SEL, 32'hff);
    bus(1'b0, ebac_pkg::REG_WAIT_B, 32'hffff);
    bus(1'b1, ebac_pkg::REG_WAIT_B, 32'h0);
    chk("wait field", 32'h7777, rdat);
    bus(1'b0, ebac_pkg::REG_WAIT_B, 32'h0);
    wait_n <= 1'b0;
    fork
      acc(0, ebac_pkg::EBAC_SPACE_EXT, 3'h0, 1'b0, n);
      begin
        repeat (6) @(posedge clk);
        wait_n <= 1'b1;
      end
    join
    // Wait pin held low over two T3 edges adds two states to the five
    chk("pin wait", 7, n);
    // All four masters at once must be served highest first
    for (int m = 0; m < 4; m++) begin
      cmd[m] <= '{1'b1, ebac_pkg::EBAC_SPACE_INT, 3'h0, 1'b0, 1'b0, 1'b1, 16'h0};
    end
    start <= 4'hf;
    @(posedge clk);
    start <= 4'h0;
    for (int k = 0; k < 40 && q.size() < 4; k++) begin
      @(posedge clk);
      for (int m = 3; m >= 0; m--) if (done[m] === 1'b1) q.push_back(m);
    end
    for (int m = 0; m < 4; m++) chk("grant order", 3 - m, q[m]);
    // Bus release and a blocking refresh hold off the CPU's external access
    for (int s = 0; s < 2; s++) begin
      rl_req <= !s;
      rf_req <= s;
      rf_mode <= 1'b1;
      repeat (4) @(posedge clk);
      fork
        acc(0, ebac_pkg::EBAC_SPACE_EXT, 3'h1, 1'b0, n);
        begin
          repeat (8) @(posedge clk);
          chk("held off", 0, ext.active || ack[0]);
          chk("release ack", !s, rl_ack);
          chk("refresh ack", s, rf_ack);
          rl_req <= 1'b0;
          rf_req <= 1'b0;
        end
      join
    end
    // Refresh with parallel mode 0 lets a plain external access run
    rf_mode <= 1'b0;
    rf_req <= 1'b1;
    acc(0, ebac_pkg::EBAC_SPACE_EXT, 3'h1, 1'b0, n);
    chk("parallel refresh", 5, n);
    rf_req <= 1'b0;
    end_sim();
  end
  // Watchdog: the whole run needs well under 4000 cycles
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule : tb_external_bus_area_control_arbiter
`default_nettype wire
